// file: rtl/flash_cmd_host.sv
// file: host sequencer driving flash command write cycles
`timescale 1ns/1ps
`default_nettype none

// Contract
// - buffered program: unlocks, 25, N, pairs
// - buffer addresses share block upper bits
// - byte mode limit 68 cycles
// - word mode limit 36, count is N
// - confirm 29 at same block address
// - bypass buffered program drops unlocks
// - bypass program A0; erase 80/30 repeatable
// - bypass chip erase 80/10, exit 90/00
// - bypass entry 20; abort F0 after unlocks
// - enhanced program 33, 256 words, confirm
// - extended block entered by three writes
// - extended block exit takes four writes
// - lock program uses ordinary program timing
// - host exits lock mode with exit command
module flash_cmd_host #(
   parameter int WE_LOW  = flash_cmd_pkg::WE_LOW_CYC,
   parameter int WE_HIGH = flash_cmd_pkg::WE_HIGH_CYC,
   parameter int RD_WAIT = flash_cmd_pkg::READ_CYC + flash_cmd_pkg::SYNC_LAT
) (
   input  wire logic                 REF_CLK_IN,
   input  wire logic                 RST_B_IN,
   input  wire logic                 CMD_VALID_IN,
   input  wire flash_cmd_pkg::cmd_t  CMD_IN,
   output logic                      CMD_READY_OUT,
   output logic                      CMD_ERR_OUT,
   input  wire logic                 DATA_VALID_IN,
   input  wire flash_cmd_pkg::load_t DATA_IN,
   output logic                      DATA_READY_OUT,
   output logic                      RD_VALID_OUT,
   output logic [15:0]               RD_DATA_OUT,
   output flash_cmd_pkg::mode_t      MODE_OUT,
   output logic [22:0]               FL_ADDR_OUT,
   input  wire logic [15:0]          FL_DQ_IN,
   output logic [15:0]               FL_DQ_OUT,
   output logic                      FL_DQ_OE_OUT,
   output logic                      FL_CE_B_OUT,
   output logic                      FL_OE_B_OUT,
   output logic                      FL_WE_B_OUT
);
   typedef enum logic [4:0] {
      S_IDLE  = 5'b00001,
      S_ISSUE = 5'b00010,
      S_WLOW  = 5'b00100,
      S_WHIGH = 5'b01000,
      S_READ  = 5'b10000
   } state_t;

   typedef enum logic [2:0] {
      P_FIX  = 3'b001,
      P_LOAD = 3'b010,
      P_CONF = 3'b100
   } phase_t;

   localparam logic [7:0] LOW_LD  = 8'(WE_LOW);
   localparam logic [7:0] HIGH_LD = 8'(WE_HIGH - 1);
   localparam logic [7:0] RD_LD   = 8'(RD_WAIT - 1);

   logic                 rst_meta;
   logic                 rst_n;
   logic [15:0]          dq_meta;
   logic [15:0]          dq_sync;
   state_t               state, next_state;
   phase_t               phase, next_phase;
   flash_cmd_pkg::mode_t mode, next_mode;
   flash_cmd_pkg::mode_t mode_after, next_mode_after;
   logic [22:0]          fix_a [4];
   logic [22:0]          next_fix_a [4];
   logic [15:0]          fix_d [4];
   logic [15:0]          next_fix_d [4];
   logic [2:0]           fix_len, next_fix_len;
   logic [8:0]           idx, next_idx;
   logic [8:0]           load_len, next_load_len;
   logic                 conf, next_conf;
   logic                 enh, next_enh;
   logic                 single, next_single;
   logic                 erase_run, next_erase_run;
   logic [22:0]          base, next_base;
   logic [7:0]           timer, next_timer;
   logic [22:0]          cur_a, next_cur_a;
   logic [15:0]          cur_d, next_cur_d;
   logic                 ce_b, next_ce_b;
   logic                 we_b, next_we_b;
   logic                 oe_b, next_oe_b;
   logic                 dq_oe, next_dq_oe;
   logic [15:0]          rd_data, next_rd_data;
   logic                 rd_valid, next_rd_valid;
   logic                 err, next_err;

   // decoded command
   logic [22:0]          nf_a [4];
   logic [15:0]          nf_d [4];
   logic [2:0]           k;
   logic                 ul;
   logic                 ok;
   logic [8:0]           n_load;
   logic                 n_conf;
   logic                 n_enh;
   logic                 n_single;
   flash_cmd_pkg::mode_t n_mode;
   logic                 in_rd, in_byp, in_ext, in_lock;

   // reset release and data pin synchroniser
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
         dq_meta  <= 16'h0000;
         dq_sync  <= 16'h0000;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
         dq_meta  <= FL_DQ_IN;
         dq_sync  <= dq_meta;
      end
   end

   assign in_rd   = (mode == flash_cmd_pkg::M_READ);
   assign in_byp  = (mode == flash_cmd_pkg::M_BYPASS);
   assign in_ext  = (mode == flash_cmd_pkg::M_EXT);
   assign in_lock = (mode == flash_cmd_pkg::M_LOCK);

   // command legality, mode effect and fixed cycle table
   always_comb begin
      nf_a     = '{default: '0};
      nf_d     = '{default: '0};
      k        = 3'd0;
      ul       = 1'b0;
      ok       = 1'b1;
      n_load   = 9'd0;
      n_conf   = 1'b0;
      n_enh    = 1'b0;
      n_single = 1'b0;
      n_mode   = mode;
      case (CMD_IN.op)
         flash_cmd_pkg::OP_READ: begin
            ok = 1'b1;
         end
         flash_cmd_pkg::OP_PROG: begin
            ul       = in_rd || in_ext;
            n_load   = 9'd1;
            n_single = 1'b1;
         end
         flash_cmd_pkg::OP_BUF_PROG: begin
            ok     = in_rd || in_byp;
            ul     = in_rd;
            n_load = 9'(CMD_IN.count) + 9'd1;
            n_conf = 1'b1;
         end
         flash_cmd_pkg::OP_ENH_PROG: begin
            ok     = in_rd || in_byp;
            ul     = in_rd;
            n_load = flash_cmd_pkg::ENH_WORDS;
            n_conf = 1'b1;
            n_enh  = 1'b1;
         end
         flash_cmd_pkg::OP_ABORT: begin
            ok = in_rd || in_byp;
            ul = 1'b1;
         end
         flash_cmd_pkg::OP_BYP_ENTER: begin
            ok     = in_rd;
            ul     = 1'b1;
            n_mode = flash_cmd_pkg::M_BYPASS;
         end
         flash_cmd_pkg::OP_BYP_EXIT: begin
            ok     = in_byp;
            n_mode = flash_cmd_pkg::M_READ;
         end
         flash_cmd_pkg::OP_BYP_ERASE: begin
            ok = in_byp;
         end
         flash_cmd_pkg::OP_ERASE_MORE: begin
            ok = in_byp && erase_run;
         end
         flash_cmd_pkg::OP_CHIP_ERASE: begin
            ok = in_byp;
         end
         flash_cmd_pkg::OP_EXT_ENTER: begin
            ok     = in_rd;
            ul     = 1'b1;
            n_mode = flash_cmd_pkg::M_EXT;
         end
         flash_cmd_pkg::OP_EXT_EXIT: begin
            ok     = in_ext;
            ul     = 1'b1;
            n_mode = flash_cmd_pkg::M_READ;
         end
         flash_cmd_pkg::OP_LOCK_ENTER: begin
            ok     = in_rd;
            ul     = 1'b1;
            n_mode = flash_cmd_pkg::M_LOCK;
         end
         flash_cmd_pkg::OP_PROT_EXIT: begin
            ok     = in_lock;
            n_mode = flash_cmd_pkg::M_READ;
         end
         default: begin
            ok = 1'b0;
         end
      endcase
      // unlock pair first
      if (ul) begin
         nf_a[0] = flash_cmd_pkg::A_UNLK1;
         nf_d[0] = flash_cmd_pkg::D_UNLK1;
         nf_a[1] = flash_cmd_pkg::A_UNLK2;
         nf_d[1] = flash_cmd_pkg::D_UNLK2;
         k       = 3'd2;
      end
      case (CMD_IN.op)
         flash_cmd_pkg::OP_PROG: begin
            nf_a[k[1:0]] = ul ? flash_cmd_pkg::A_UNLK1
                              : flash_cmd_pkg::A_ANY;
            nf_d[k[1:0]] = flash_cmd_pkg::D_PROG;
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_BUF_PROG: begin
            nf_a[k[1:0]] = CMD_IN.addr;
            nf_d[k[1:0]] = flash_cmd_pkg::D_BUF;
            k = k + 3'd1;
            nf_a[k[1:0]] = CMD_IN.addr;
            nf_d[k[1:0]] = 16'(CMD_IN.count);
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_ENH_PROG: begin
            nf_a[k[1:0]] = CMD_IN.addr;
            nf_d[k[1:0]] = flash_cmd_pkg::D_ENH;
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_ABORT: begin
            nf_a[k[1:0]] = flash_cmd_pkg::A_UNLK1;
            nf_d[k[1:0]] = flash_cmd_pkg::D_ABORT;
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_BYP_ENTER: begin
            nf_a[k[1:0]] = flash_cmd_pkg::A_UNLK1;
            nf_d[k[1:0]] = flash_cmd_pkg::D_BYP;
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_BYP_ERASE: begin
            nf_a[0] = flash_cmd_pkg::A_ANY;
            nf_d[0] = flash_cmd_pkg::D_ERASE;
            nf_a[1] = CMD_IN.addr;
            nf_d[1] = flash_cmd_pkg::D_BLK;
            k = 3'd2;
         end
         flash_cmd_pkg::OP_ERASE_MORE: begin
            nf_a[0] = CMD_IN.addr;
            nf_d[0] = flash_cmd_pkg::D_BLK;
            k = 3'd1;
         end
         flash_cmd_pkg::OP_CHIP_ERASE: begin
            nf_a[0] = flash_cmd_pkg::A_ANY;
            nf_d[0] = flash_cmd_pkg::D_ERASE;
            nf_a[1] = flash_cmd_pkg::A_ANY;
            nf_d[1] = flash_cmd_pkg::D_CHIP;
            k = 3'd2;
         end
         flash_cmd_pkg::OP_EXT_ENTER: begin
            nf_a[k[1:0]] = flash_cmd_pkg::A_UNLK1;
            nf_d[k[1:0]] = flash_cmd_pkg::D_EXT_IN;
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_EXT_EXIT: begin
            nf_a[2] = flash_cmd_pkg::A_UNLK1;
            nf_d[2] = flash_cmd_pkg::D_EXIT1;
            nf_a[3] = flash_cmd_pkg::A_ANY;
            nf_d[3] = flash_cmd_pkg::D_EXIT2;
            k = 3'd4;
         end
         flash_cmd_pkg::OP_LOCK_ENTER: begin
            nf_a[k[1:0]] = flash_cmd_pkg::A_UNLK1;
            nf_d[k[1:0]] = flash_cmd_pkg::D_LOCK;
            k = k + 3'd1;
         end
         flash_cmd_pkg::OP_BYP_EXIT,
         flash_cmd_pkg::OP_PROT_EXIT: begin
            nf_a[0] = flash_cmd_pkg::A_ANY;
            nf_d[0] = flash_cmd_pkg::D_EXIT1;
            nf_a[1] = flash_cmd_pkg::A_ANY;
            nf_d[1] = flash_cmd_pkg::D_EXIT2;
            k = 3'd2;
         end
         default: begin
            k = k;
         end
      endcase
   end

   // sequencer next state
   always_comb begin
      next_state      = state;
      next_phase      = phase;
      next_mode       = mode;
      next_mode_after = mode_after;
      next_fix_a      = fix_a;
      next_fix_d      = fix_d;
      next_fix_len    = fix_len;
      next_idx        = idx;
      next_load_len   = load_len;
      next_conf       = conf;
      next_enh        = enh;
      next_single     = single;
      next_erase_run  = erase_run;
      next_base       = base;
      next_timer      = timer;
      next_cur_a      = cur_a;
      next_cur_d      = cur_d;
      next_rd_data    = rd_data;
      next_rd_valid   = 1'b0;
      next_err        = 1'b0;
      case (state)
         S_IDLE: begin
            if (CMD_VALID_IN) begin
               if (CMD_IN.op == flash_cmd_pkg::OP_READ) begin
                  next_cur_a = CMD_IN.addr;
                  next_timer = RD_LD;
                  next_state = S_READ;
               end else if (ok) begin
                  next_fix_a      = nf_a;
                  next_fix_d      = nf_d;
                  next_fix_len    = k;
                  next_load_len   = n_load;
                  next_conf       = n_conf;
                  next_enh        = n_enh;
                  next_single     = n_single;
                  next_base       = CMD_IN.addr;
                  next_mode_after = n_mode;
                  next_idx        = 9'd0;
                  next_phase      = P_FIX;
                  next_erase_run  =
                     (CMD_IN.op == flash_cmd_pkg::OP_BYP_ERASE) ||
                     (CMD_IN.op == flash_cmd_pkg::OP_ERASE_MORE);
                  next_state      = S_ISSUE;
               end else begin
                  next_err = 1'b1;
               end
            end
         end
         S_ISSUE: begin
            case (phase)
               P_FIX: begin
                  if (idx[2:0] < fix_len) begin
                     next_cur_a = fix_a[idx[1:0]];
                     next_cur_d = fix_d[idx[1:0]];
                     next_idx   = idx + 9'd1;
                     next_timer = LOW_LD;
                     next_state = S_WLOW;
                  end else begin
                     next_idx   = 9'd0;
                     next_phase = P_LOAD;
                  end
               end
               P_LOAD: begin
                  if (idx >= load_len) begin
                     next_phase = P_CONF;
                  end else if (DATA_VALID_IN) begin
                     if (single) begin
                        next_cur_a = base;
                     end else if (enh) begin
                        next_cur_a = {base[22:flash_cmd_pkg::EBLK_LSB],
                           idx[flash_cmd_pkg::EBLK_LSB-1:0]};
                     end else begin
                        next_cur_a = {base[22:flash_cmd_pkg::PAGE_LSB],
                           DATA_IN.offset};
                     end
                     next_cur_d = DATA_IN.data;
                     next_idx   = idx + 9'd1;
                     next_timer = LOW_LD;
                     next_state = S_WLOW;
                  end
               end
               P_CONF: begin
                  if (conf) begin
                     next_cur_a = enh ?
                        {base[22:flash_cmd_pkg::EBLK_LSB],
                         {flash_cmd_pkg::EBLK_LSB{1'b0}}} : base;
                     next_cur_d = flash_cmd_pkg::D_CONF;
                     next_conf  = 1'b0;
                     next_timer = LOW_LD;
                     next_state = S_WLOW;
                  end else begin
                     next_mode  = mode_after;
                     next_state = S_IDLE;
                  end
               end
               default: begin
                  next_state = S_IDLE;
               end
            endcase
         end
         S_WLOW: begin
            if (timer == 8'd0) begin
               next_timer = HIGH_LD;
               next_state = S_WHIGH;
            end else begin
               next_timer = timer - 8'd1;
            end
         end
         S_WHIGH: begin
            if (timer == 8'd0) begin
               next_state = S_ISSUE;
            end else begin
               next_timer = timer - 8'd1;
            end
         end
         S_READ: begin
            if (timer == 8'd0) begin
               next_rd_data  = dq_sync;
               next_rd_valid = 1'b1;
               next_state    = S_IDLE;
            end else begin
               next_timer = timer - 8'd1;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      // pin strobes, write enable after one address setup cycle
      next_ce_b  = !(next_state == S_WLOW || next_state == S_WHIGH ||
                     next_state == S_READ);
      next_we_b  = !(next_state == S_WLOW && state == S_WLOW);
      next_oe_b  = (next_state != S_READ);
      next_dq_oe = (next_state == S_WLOW || next_state == S_WHIGH);
   end

   // sequencer registers
   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         state      <= S_IDLE;
         phase      <= P_FIX;
         mode       <= flash_cmd_pkg::M_READ;
         mode_after <= flash_cmd_pkg::M_READ;
         fix_a      <= '{default: '0};
         fix_d      <= '{default: '0};
         fix_len    <= 3'd0;
         idx        <= 9'd0;
         load_len   <= 9'd0;
         conf       <= 1'b0;
         enh        <= 1'b0;
         single     <= 1'b0;
         erase_run  <= 1'b0;
         base       <= 23'h000000;
         timer      <= 8'h00;
         cur_a      <= 23'h000000;
         cur_d      <= 16'h0000;
         ce_b       <= 1'b1;
         we_b       <= 1'b1;
         oe_b       <= 1'b1;
         dq_oe      <= 1'b0;
         rd_data    <= 16'h0000;
         rd_valid   <= 1'b0;
         err        <= 1'b0;
      end else begin
         state      <= next_state;
         phase      <= next_phase;
         mode       <= next_mode;
         mode_after <= next_mode_after;
         fix_a      <= next_fix_a;
         fix_d      <= next_fix_d;
         fix_len    <= next_fix_len;
         idx        <= next_idx;
         load_len   <= next_load_len;
         conf       <= next_conf;
         enh        <= next_enh;
         single     <= next_single;
         erase_run  <= next_erase_run;
         base       <= next_base;
         timer      <= next_timer;
         cur_a      <= next_cur_a;
         cur_d      <= next_cur_d;
         ce_b       <= next_ce_b;
         we_b       <= next_we_b;
         oe_b       <= next_oe_b;
         dq_oe      <= next_dq_oe;
         rd_data    <= next_rd_data;
         rd_valid   <= next_rd_valid;
         err        <= next_err;
      end
   end

   // handshakes and pins
   assign CMD_READY_OUT  = (state == S_IDLE);
   assign DATA_READY_OUT = (state == S_ISSUE) && (phase == P_LOAD) &&
                           (idx < load_len);
   assign CMD_ERR_OUT    = err;
   assign RD_VALID_OUT   = rd_valid;
   assign RD_DATA_OUT    = rd_data;
   assign MODE_OUT       = mode;
   assign FL_ADDR_OUT    = cur_a;
   assign FL_DQ_OUT      = cur_d;
   assign FL_DQ_OE_OUT   = dq_oe;
   assign FL_CE_B_OUT    = ce_b;
   assign FL_OE_B_OUT    = oe_b;
   assign FL_WE_B_OUT    = we_b;
endmodule

`default_nettype wire

// file: include/flash_cmd_pkg.sv
// package: flash command codes, cycle addresses, timing and carriers
package flash_cmd_pkg;
   localparam int ADDR_W   = 23;
   localparam int DATA_W   = 16;
   localparam int CNT_W    = 5;
   localparam int IDX_W    = 9;
   localparam int TMR_W    = 8;
   localparam int PAGE_LSB = 5;  // write buffer page starts at A5
   localparam int EBLK_LSB = 8;  // enhanced offsets 00..FF
   localparam int SYNC_LAT = 2;  // data pin synchroniser depth

   // fixed cycle addresses, word mode
   localparam logic [22:0] A_UNLK1 = 23'h000555;
   localparam logic [22:0] A_UNLK2 = 23'h0002AA;
   localparam logic [22:0] A_ANY   = 23'h000000;

   // data codes
   localparam logic [15:0] D_UNLK1  = 16'h00AA;
   localparam logic [15:0] D_UNLK2  = 16'h0055;
   localparam logic [15:0] D_BUF    = 16'h0025;
   localparam logic [15:0] D_CONF   = 16'h0029;
   localparam logic [15:0] D_ENH    = 16'h0033;
   localparam logic [15:0] D_ABORT  = 16'h00F0;
   localparam logic [15:0] D_BYP    = 16'h0020;
   localparam logic [15:0] D_PROG   = 16'h00A0;
   localparam logic [15:0] D_ERASE  = 16'h0080;
   localparam logic [15:0] D_BLK    = 16'h0030;
   localparam logic [15:0] D_CHIP   = 16'h0010;
   localparam logic [15:0] D_EXIT1  = 16'h0090;
   localparam logic [15:0] D_EXIT2  = 16'h0000;
   localparam logic [15:0] D_EXT_IN = 16'h0088;
   localparam logic [15:0] D_LOCK   = 16'h0040;

   localparam logic [8:0] ENH_WORDS = 9'h100;

   // bus timing, least times in ns, clock in MHz
   localparam int CLK_MHZ      = 200;
   localparam int T_WE_LOW_NS  = 50;
   localparam int T_WE_HIGH_NS = 30;
   localparam int T_READ_NS    = 100;
   localparam int WE_LOW_CYC  = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC    = (T_READ_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [3:0] {
      OP_READ       = 4'h0,
      OP_PROG       = 4'h1,
      OP_BUF_PROG   = 4'h2,
      OP_ENH_PROG   = 4'h3,
      OP_ABORT      = 4'h4,
      OP_BYP_ENTER  = 4'h5,
      OP_BYP_EXIT   = 4'h6,
      OP_BYP_ERASE  = 4'h7,
      OP_ERASE_MORE = 4'h8,
      OP_CHIP_ERASE = 4'h9,
      OP_EXT_ENTER  = 4'hA,
      OP_EXT_EXIT   = 4'hB,
      OP_LOCK_ENTER = 4'hC,
      OP_PROT_EXIT  = 4'hD
   } op_t;

   typedef enum logic [3:0] {
      M_READ   = 4'b0001,
      M_BYPASS = 4'b0010,
      M_EXT    = 4'b0100,
      M_LOCK   = 4'b1000
   } mode_t;

   typedef struct packed {
      op_t         op;
      logic [22:0] addr;
      logic [4:0]  count;
   } cmd_t;

   typedef struct packed {
      logic [4:0]  offset;
      logic [15:0] data;
   } load_t;
endpackage

// file: verification/flash_cmd_host_monitor.sv
// checker: strobe, read and mode assertions
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_host_monitor #(
   parameter int WE_LOW = 10
) (
   input wire logic                 REF_CLK_IN,
   input wire logic                 RST_B_IN,
   input wire logic                 CMD_VALID_IN,
   input wire flash_cmd_pkg::cmd_t  CMD_IN,
   input wire logic                 CMD_READY_OUT,
   input wire logic                 CMD_ERR_OUT,
   input wire logic                 RD_VALID_OUT,
   input wire flash_cmd_pkg::mode_t MODE_OUT,
   input wire logic [22:0]          FL_ADDR_OUT,
   input wire logic [15:0]          FL_DQ_OUT,
   input wire logic                 FL_DQ_OE_OUT,
   input wire logic                 FL_CE_B_OUT,
   input wire logic                 FL_OE_B_OUT,
   input wire logic                 FL_WE_B_OUT
);
   logic [7:0] low_cnt;
   logic [7:0] next_low_cnt;
   logic       take;
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // cycles spent with write strobe low
   always_comb next_low_cnt = FL_WE_B_OUT ? 8'h00 : low_cnt + 8'h01;
   always_ff @(posedge REF_CLK_IN or negedge RST_B_IN)
      if (!RST_B_IN) low_cnt <= 8'h00;
      else low_cnt <= next_low_cnt;
   // command taken
   assign take = CMD_VALID_IN && CMD_READY_OUT;
   AST_WE_LOW_LEN: assert property ($rose(FL_WE_B_OUT) |->
      low_cnt == 8'(WE_LOW)) else $error("write strobe width wrong");
   AST_WE_QUAL: assert property (!FL_WE_B_OUT |->
      !FL_CE_B_OUT && FL_DQ_OE_OUT && FL_OE_B_OUT) else $error("bad write");
   AST_WE_HOLD: assert property (!FL_WE_B_OUT && !$past(FL_WE_B_OUT)
      |-> $stable(FL_DQ_OUT) && $stable(FL_ADDR_OUT))
      else $error("write data moved");
   AST_RD_QUAL: assert property (!FL_OE_B_OUT |->
      !FL_CE_B_OUT && FL_WE_B_OUT && !FL_DQ_OE_OUT) else $error("bad read");
   AST_RD_ANS: assert property (
      take && CMD_IN.op == flash_cmd_pkg::OP_READ |-> ##[1:200] RD_VALID_OUT)
      else $error("read not answered");
   AST_ONEHOT: assert property ($onehot(MODE_OUT))
      else $error("mode not one-hot");
   AST_MODE_BUSY: assert property ($changed(MODE_OUT) |->
      !$past(CMD_READY_OUT)) else $error("mode moved while idle");
   AST_FROM_READ: assert property (
      $changed(MODE_OUT) && MODE_OUT != flash_cmd_pkg::M_READ
      |-> $past(MODE_OUT) == flash_cmd_pkg::M_READ)
      else $error("mode entered from wrong mode");
   AST_ERR_QUIET: assert property (CMD_ERR_OUT |->
      FL_CE_B_OUT && CMD_READY_OUT && $past(CMD_VALID_IN))
      else $error("refusal touched the bus");
   AST_EXT_REFUSE: assert property (
      take && MODE_OUT == flash_cmd_pkg::M_EXT && CMD_IN.op inside
      {flash_cmd_pkg::OP_BYP_ENTER, flash_cmd_pkg::OP_BYP_ERASE,
      flash_cmd_pkg::OP_CHIP_ERASE} |=> CMD_ERR_OUT)
      else $error("command not refused in extended mode");
   COV_BUF: cover property (take && CMD_IN.op == flash_cmd_pkg::OP_BUF_PROG);
   COV_ERR: cover property (CMD_ERR_OUT);
   COV_RD: cover property (RD_VALID_OUT);
endmodule
bind flash_cmd_host flash_cmd_host_monitor #(.WE_LOW(WE_LOW))
   flash_cmd_host_monitor_inst (.REF_CLK_IN, .RST_B_IN, .CMD_VALID_IN,
   .CMD_IN, .CMD_READY_OUT, .CMD_ERR_OUT, .RD_VALID_OUT, .MODE_OUT,
   .FL_ADDR_OUT, .FL_DQ_OUT, .FL_DQ_OE_OUT, .FL_CE_B_OUT, .FL_OE_B_OUT,
   .FL_WE_B_OUT);
`default_nettype wire

// file: verification/flash_dev_model.sv
// partner: flash device logging write cycles and answering reads
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
   input  wire logic [22:0] addr_in,
   input  wire logic [15:0] dq_in,
   input  wire logic        ce_b_in,
   input  wire logic        oe_b_in,
   input  wire logic        we_b_in,
   output logic [15:0]      dq_out,
   output logic             dq_en_out
);
   logic [38:0] wr [$];
   // address and data latched on write strobe rise, word mode
   always @(posedge we_b_in) begin
      if (!ce_b_in) wr.push_back({addr_in, dq_in});
   end
   // array contents in any read mode, driven only while selected
   assign dq_en_out = !ce_b_in && !oe_b_in;
   assign dq_out = addr_in[15:0] ^ 16'hC3C3;
endmodule
`default_nettype wire

// file: verification/flash_cmd_host_tb.sv
// testbench: command table and reset cases for the flash host
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin \
   err_count++; $display("Error %s exp %0h got %0h", nm, e, s); end end
module flash_cmd_host_tb;
   typedef struct {logic [3:0] op; logic [22:0] a; logic [4:0] n;
      int nwr; logic [3:0] m; logic [38:0] last;} row_t;
   // op, address, count, bus writes, mode after, last write
   row_t rows [18] = '{
      '{4'h5, 23'h0, 5'h0, 3, 4'h2, 39'h555_0020},
      '{4'h1, 23'h100, 5'h0, 2, 4'h2, 39'h100_1234},
      '{4'h7, 23'h10000, 5'h0, 2, 4'h2, 39'h10000_0030},
      '{4'h8, 23'h20000, 5'h0, 1, 4'h2, 39'h20000_0030},
      '{4'h9, 23'h0, 5'h0, 2, 4'h2, 39'h0_0010},
      '{4'h2, 23'h12340, 5'h1, 5, 4'h2, 39'h12340_0029},
      '{4'h3, 23'h45655, 5'h0, 258, 4'h2, 39'h45600_0029},
      '{4'h4, 23'h0, 5'h0, 3, 4'h2, 39'h555_00F0},
      '{4'h0, 23'h333, 5'h0, 0, 4'h2, 39'h0},
      '{4'h6, 23'h0, 5'h0, 2, 4'h1, 39'h0_0000},
      '{4'h2, 23'h12340, 5'h1F, 37, 4'h1, 39'h12340_0029},
      '{4'h3, 23'h45655, 5'h0, 260, 4'h1, 39'h45600_0029},
      '{4'hA, 23'h0, 5'h0, 3, 4'h4, 39'h555_0088},
      '{4'h7, 23'h0, 5'h0, 0, 4'h4, 39'h0},
      '{4'hB, 23'h0, 5'h0, 4, 4'h1, 39'h0_0000},
      '{4'hC, 23'h0, 5'h0, 3, 4'h8, 39'h555_0040},
      '{4'h1, 23'h7, 5'h0, 2, 4'h8, 39'h7_1234},
      '{4'hD, 23'h0, 5'h0, 2, 4'h1, 39'h0_0000}};
   logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, dat_valid = 1'b0;
   logic tog = 1'b0, ready, err, dat_ready, rd_valid, dq_oe, dev_en;
   logic ce_b, oe_b, we_b;
   logic [15:0] rd_data, dq_out, dev_dq, dq, rd;
   logic [22:0] addr;
   flash_cmd_pkg::cmd_t  cmd = '0;
   flash_cmd_pkg::load_t dat = '0;
   flash_cmd_pkg::mode_t mode;
   int err_count = 0, num_checks = 0, errs = 0;
   // clock, released-bus pattern, refusal and read capture
   always #2.5 clk = ~clk;
   always @(posedge clk) tog <= ~tog;
   always @(posedge clk) if (err === 1'b1) errs++;
   always @(posedge clk) if (rd_valid === 1'b1) rd = rd_data;
   assign dq = dq_oe ? dq_out : dev_en ? dev_dq : {16{tog}};
   flash_cmd_host #(.WE_LOW(2), .WE_HIGH(2), .RD_WAIT(3)) flash_cmd_host_inst (
      .REF_CLK_IN(clk), .RST_B_IN(rst_b), .CMD_VALID_IN(cmd_valid),
      .CMD_IN(cmd), .CMD_READY_OUT(ready), .CMD_ERR_OUT(err),
      .DATA_VALID_IN(dat_valid), .DATA_IN(dat), .DATA_READY_OUT(dat_ready),
      .RD_VALID_OUT(rd_valid), .RD_DATA_OUT(rd_data), .MODE_OUT(mode),
      .FL_ADDR_OUT(addr), .FL_DQ_IN(dq), .FL_DQ_OUT(dq_out),
      .FL_DQ_OE_OUT(dq_oe), .FL_CE_B_OUT(ce_b), .FL_OE_B_OUT(oe_b),
      .FL_WE_B_OUT(we_b));
   flash_dev_model flash_dev_model_inst (.addr_in(addr), .dq_in(dq),
      .ce_b_in(ce_b), .oe_b_in(oe_b), .we_b_in(we_b), .dq_out(dev_dq),
      .dq_en_out(dev_en));
   // verdict and end of run
   task automatic end_sim;
      if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one command with its load words, then compare the bus log
   task automatic run(input row_t r);
      int n0, e0, k;
      bit hit;
      n0 = flash_dev_model_inst.wr.size();
      e0 = errs;
      cmd = '{flash_cmd_pkg::op_t'(r.op), r.a, r.n};
      dat = '{5'h00, 16'h1234};
      cmd_valid = 1'b1;
      dat_valid = 1'b1;
      @(posedge clk);
      #1 cmd_valid = 1'b0;
      for (k = 0; k < 4000 && ready !== 1'b1; k++) begin
         hit = dat_ready === 1'b1;
         @(posedge clk);
         #1;
         if (hit) dat.offset++;
      end
      if (k == 4000) begin
         err_count++;
         end_sim();
      end
      dat_valid = 1'b0;
      @(posedge clk);
      #1;
      `CHK("writes", r.nwr, flash_dev_model_inst.wr.size() - n0)
      `CHK("mode", r.m, mode)
      `CHK("refused", r.nwr == 0 && r.op != 4'h0, errs != e0)
      if (r.nwr > 0) `CHK("last", r.last, flash_dev_model_inst.wr[$])
      if (r.op == 4'h0) `CHK("read", r.a[15:0] ^ 16'hC3C3, rd)
   endtask
   // reset, table, then reset in extended mode
   initial begin
      repeat (20) @(posedge clk);
      #1;
      `CHK("reset mode", 4'h1, mode)
      `CHK("strobes", 3'h7, {ce_b, oe_b, we_b})
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      foreach (rows[i]) run(rows[i]);
      run(rows[12]);
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK("mid reset mode", 4'h1, mode)
      rst_b = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      run(rows[0]);
      end_sim();
   end
endmodule
`default_nettype wire
